// [common/tdc_pkg.sv]
`default_nettype none
package tdc_pkg;
	// Register byte offsets
	localparam logic [7:0] MAIN_CONTROL_OFS = 8'h00;
	localparam logic [7:0] LOOP_MODE_OFS    = 8'h04;
	localparam logic [7:0] HOUSEKEEP_OFS    = 8'h08;
	localparam logic [7:0] OUT_ADJUST_OFS   = 8'h0C;
	// Field positions
	localparam int BYPASS_BIT   = 14;
	localparam int FREERUN_BIT  = 0;
	localparam int FREQ_LSB     = 1;
	localparam int REF_POLARITY_INVERT_BIT     = 3;
	localparam int REFSEL_BIT   = 4;
	localparam int COARSE_LSB   = 0;
	localparam int SKEW_LSB     = 8;
	localparam int FAIL_BIT     = 0;
	// Reset values
	localparam logic [15:0] CTRL_RESET   = 16'h0000;
	localparam logic [4:0]  MODE_RESET   = 5'h00;
	localparam logic [9:0]  ADJUST_RESET = 10'h000;
	// Frequency field codes
	localparam logic [1:0] FREQ_8K  = 2'b00;
	localparam logic [1:0] FREQ_1M5 = 2'b01;
	localparam logic [1:0] FREQ_2M  = 2'b10;
	// Timing, clock 200 MHz
	localparam int CLK_MHZ      = 200;
	localparam int MIN_PHASE_NS = 90;
	localparam int MIN_PHASE_CY = (MIN_PHASE_NS * CLK_MHZ + 999) / 1000;
	localparam int PER_8K_CY    = 25000;
	localparam int PER_1M5_CY   = 130;
	localparam int PER_2M_CY    = 98;
	localparam int SPAN_CYCLES  = 64;
	localparam int SPAN_LO      = 62;
	localparam int SPAN_HI      = 66;
	localparam int SKEW_STEP_PS = 1900;
	localparam int SKEW_TAPS    = 8;
	typedef enum logic [2:0]
	{
		MODE_LOCKED  = 3'b001,
		MODE_FREERUN = 3'b010,
		MODE_BYPASS  = 3'b100
	} tdc_mode_t;
	typedef struct packed
	{
		logic       refSourceSelect;
		logic       refPolarityInvert;
		logic [1:0] refFrequencyField;
		logic       freeRun;
	} tdc_loop_mode_t;
	typedef struct packed
	{
		logic [2:0] fineSkewField;
		logic [6:0] coarsePhaseOffsetField;
	} tdc_adjust_t;
endpackage : tdc_pkg
`default_nettype wire

// [logic/tdc_timing_control.sv]
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tdc_timing_control #(
	parameter int PER_8K = tdc_pkg::PER_8K_CY,
	parameter int CW     = 16
)(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        nrst,
	// AXI4-Lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Timing pins
	input  wire logic        serialInputClock,
	input  wire logic        serialInputFramePulse,
	input  wire logic        networkReference,
	// Loop-facing controls
	output var  logic [2:0]  loopMode,
	output var  logic        multiplierUsesInputClock,
	output var  logic        loopReference,
	output var  logic        freqOffsetEnable,
	output var  logic signed [7:0] phaseError,
	output var  logic        inputFrameStart,
	output var  logic        referenceFailFlag
);
	logic [15:0] mainControlReg;
	logic [4:0]  loopOperationModeReg;
	logic [9:0]  loopOutputAdjustReg;
	logic [15:0] next_mainControlReg;
	logic [4:0]  next_loopOperationModeReg;
	logic [9:0]  next_loopOutputAdjustReg;
	logic        awHeld, wHeld, next_awHeld, next_wHeld;
	logic [7:0]  awAddr, next_awAddr;
	logic [31:0] wData, next_wData;
	logic [3:0]  wStrb, next_wStrb;
	logic        next_bvalid, next_rvalid, next_arready;
	logic        next_awready, next_wready;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata;
	function automatic logic isMapped(input logic [7:0] a);
		isMapped = (a == tdc_pkg::MAIN_CONTROL_OFS) ||
			(a == tdc_pkg::LOOP_MODE_OFS) ||
			(a == tdc_pkg::HOUSEKEEP_OFS) ||
			(a == tdc_pkg::OUT_ADJUST_OFS);
	endfunction : isMapped
	always_comb
	begin
		next_awHeld = awHeld;
		next_wHeld = wHeld;
		next_awAddr = awAddr;
		next_wData = wData;
		next_wStrb = wStrb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_mainControlReg = mainControlReg;
		next_loopOperationModeReg = loopOperationModeReg;
		next_loopOutputAdjustReg = loopOutputAdjustReg;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_awHeld = 1'b1;
			next_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_wHeld = 1'b1;
			next_wData = s_axi_wdata;
			next_wStrb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		if (awHeld && wHeld && !s_axi_bvalid)
		begin
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = isMapped(awAddr) ? 2'b00 : 2'b10;
			// Freerun may be entered at any time without reset
			case (awAddr)
				tdc_pkg::MAIN_CONTROL_OFS:
				begin
					if (wStrb[0])
						next_mainControlReg[7:0] = wData[7:0];
					if (wStrb[1])
						next_mainControlReg[15:8] = wData[15:8];
				end
				tdc_pkg::LOOP_MODE_OFS:
					if (wStrb[0])
						next_loopOperationModeReg = wData[4:0];
				tdc_pkg::OUT_ADJUST_OFS:
				begin
					if (wStrb[0])
						next_loopOutputAdjustReg[6:0] = wData[6:0];
					if (wStrb[1])
						next_loopOutputAdjustReg[9:7] = wData[10:8];
				end
				default:
					next_bresp = next_bresp;
			endcase
		end
		next_awready = !next_awHeld && !next_bvalid;
		next_wready = !next_wHeld && !next_bvalid;
	end
	always_comb
	begin
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready)
			next_rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_rvalid = 1'b1;
			next_rresp = isMapped(s_axi_araddr) ? 2'b00 : 2'b10;
			case (s_axi_araddr)
				tdc_pkg::MAIN_CONTROL_OFS:
					next_rdata = {16'h0000, mainControlReg};
				tdc_pkg::LOOP_MODE_OFS:
					next_rdata = {27'h000_0000, loopOperationModeReg};
				tdc_pkg::HOUSEKEEP_OFS:
					next_rdata = {31'h0000_0000, referenceFailFlag};
				tdc_pkg::OUT_ADJUST_OFS:
					next_rdata = {21'h00_0000, loopOutputAdjustReg[9:7],
						1'b0, loopOutputAdjustReg[6:0]};
				default:
					next_rdata = 32'h0000_0000;
			endcase
		end
		next_arready = !next_rvalid;
	end
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			mainControlReg <= tdc_pkg::CTRL_RESET;
			loopOperationModeReg <= tdc_pkg::MODE_RESET;
			loopOutputAdjustReg <= tdc_pkg::ADJUST_RESET;
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= 8'h00;
			wData <= 32'h0000_0000;
			wStrb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end
		else
		begin
			mainControlReg <= next_mainControlReg;
			loopOperationModeReg <= next_loopOperationModeReg;
			loopOutputAdjustReg <= next_loopOutputAdjustReg;
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			awAddr <= next_awAddr;
			wData <= next_wData;
			wStrb <= next_wStrb;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end
	tdc_pkg::tdc_loop_mode_t modeF;
	tdc_pkg::tdc_adjust_t    adjF;
	assign modeF = loopOperationModeReg;
	assign adjF = loopOutputAdjustReg;
	// Pin synchronisers; first stage read only by the second
	logic [2:0] syncA, syncB;
	logic       ckiPrev, refPrev;
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			syncA <= 3'b000;
			syncB <= 3'b000;
		end
		else
		begin
			syncA <= {networkReference, serialInputFramePulse,
				serialInputClock};
			syncB <= syncA;
		end
	end
	// Frame pulse sampled on input clock rising edge
	logic ckiRise, derived8kReference, next_derived8k;
	logic refInt, refRaw, skewedRef, refRise;
	assign ckiRise = syncB[0] && !ckiPrev;
	assign next_derived8k = ckiRise ? syncB[1] : derived8kReference;
	assign refRaw = syncB[2] ^ modeF.refPolarityInvert;
	assign refInt = modeF.refSourceSelect ? derived8kReference : refRaw;
	// Delay line: one tap per clock; 5 ns steps stand in for 1.9 ns taps
	logic [tdc_pkg::SKEW_TAPS-1:0] tapLine, tapIn;
	// Tap inputs gathered in one vector so no tap indexes below zero
	assign tapIn = {tapLine[tdc_pkg::SKEW_TAPS-2:0], refInt};
	genvar gi;
	generate
		for (gi = 0; gi < tdc_pkg::SKEW_TAPS; gi++)
		begin : g_tap
			always_ff @(posedge clock)
			begin
				if (!nrst)
					tapLine[gi] <= 1'b0;
				else
					tapLine[gi] <= tapIn[gi];
			end
		end
	endgenerate
	assign skewedRef = tapLine[adjF.fineSkewField];
	assign refRise = skewedRef && !refPrev;
	// Monitor counters in master clock cycles
	logic [CW-1:0] phaseCnt, periodCnt, next_phaseCnt, next_periodCnt;
	logic [CW+6:0] spanCnt, next_spanCnt;
	logic [5:0]    spanEdges, next_spanEdges;
	logic          phaseBad, periodBad, spanBad, sawEdge;
	logic          next_phaseBad, next_periodBad, next_spanBad, next_sawEdge;
	logic [CW-1:0] nomPer, perTol;
	always_comb
	begin
		case (modeF.refFrequencyField)
			tdc_pkg::FREQ_1M5:
				nomPer = CW'(tdc_pkg::PER_1M5_CY);
			tdc_pkg::FREQ_2M:
				nomPer = CW'(tdc_pkg::PER_2M_CY);
			default:
				nomPer = CW'(PER_8K);
		endcase
		perTol = (modeF.refFrequencyField == tdc_pkg::FREQ_8K) ?
			(nomPer >> 5) : (nomPer >> 2);
	end
	always_comb
	begin
		next_phaseCnt = (skewedRef != refPrev) ? CW'(1) : phaseCnt + CW'(1);
		next_phaseBad = phaseBad;
		if (skewedRef != refPrev)
			next_phaseBad = phaseCnt < CW'(tdc_pkg::MIN_PHASE_CY);
		next_periodCnt = periodCnt + CW'(1);
		next_periodBad = periodBad;
		next_spanCnt = spanCnt + (CW+7)'(1);
		next_spanEdges = spanEdges;
		next_spanBad = spanBad;
		next_sawEdge = sawEdge;
		if (refRise)
		begin
			next_sawEdge = 1'b1;
			next_periodCnt = CW'(1);
			if (sawEdge)
				next_periodBad = (periodCnt > nomPer + perTol) ||
					(periodCnt < nomPer - perTol);
			next_spanEdges = spanEdges + 6'd1;
			if (spanEdges == 6'd63)
			begin
				next_spanCnt = (CW+7)'(1);
				next_spanBad = (modeF.refFrequencyField != tdc_pkg::FREQ_8K)
					&& ((spanCnt < (CW+7)'(nomPer) * (CW+7)'(tdc_pkg::SPAN_LO))
					|| (spanCnt > (CW+7)'(nomPer) * (CW+7)'(tdc_pkg::SPAN_HI)));
			end
		end
		else if (periodCnt > nomPer + perTol)
			next_periodBad = 1'b1;
	end
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			ckiPrev <= 1'b0;
			refPrev <= 1'b0;
			derived8kReference <= 1'b0;
			phaseCnt <= '0;
			periodCnt <= '0;
			spanCnt <= '0;
			spanEdges <= 6'd0;
			phaseBad <= 1'b0;
			periodBad <= 1'b0;
			spanBad <= 1'b0;
			sawEdge <= 1'b0;
		end
		else
		begin
			ckiPrev <= syncB[0];
			refPrev <= skewedRef;
			derived8kReference <= next_derived8k;
			phaseCnt <= next_phaseCnt;
			periodCnt <= next_periodCnt;
			spanCnt <= next_spanCnt;
			spanEdges <= next_spanEdges;
			phaseBad <= next_phaseBad;
			periodBad <= next_periodBad;
			spanBad <= next_spanBad;
			sawEdge <= next_sawEdge;
		end
	end
	// Loop-facing outputs
	tdc_pkg::tdc_mode_t next_mode;
	logic signed [7:0] next_phaseError;
	always_comb
	begin
		if (mainControlReg[tdc_pkg::BYPASS_BIT])
			next_mode = tdc_pkg::MODE_BYPASS;
		else if (modeF.freeRun)
			next_mode = tdc_pkg::MODE_FREERUN;
		else
			next_mode = tdc_pkg::MODE_LOCKED;
		// Error sign: +1 on reference edge, offset bias added
		next_phaseError = 8'(signed'(adjF.coarsePhaseOffsetField));
		if (refRise)
			next_phaseError = next_phaseError + 8'sd1;
	end
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			loopMode <= tdc_pkg::MODE_LOCKED;
			multiplierUsesInputClock <= 1'b0;
			loopReference <= 1'b0;
			freqOffsetEnable <= 1'b0;
			phaseError <= 8'sd0;
			inputFrameStart <= 1'b0;
			referenceFailFlag <= 1'b0;
		end
		else
		begin
			loopMode <= next_mode;
			// Oscillator feeds multiplier unless bypassed
			multiplierUsesInputClock <=
				(next_mode == tdc_pkg::MODE_BYPASS);
			// Freerun drops reference and frequency offset
			loopReference <=
				(next_mode == tdc_pkg::MODE_LOCKED) && skewedRef;
			freqOffsetEnable <= (next_mode == tdc_pkg::MODE_LOCKED);
			phaseError <= (next_mode == tdc_pkg::MODE_LOCKED) ?
				next_phaseError : 8'sd0;
			inputFrameStart <= ckiRise && !syncB[1];
			referenceFailFlag <= next_phaseBad || next_periodBad ||
				next_spanBad;
		end
	end
endmodule : tdc_timing_control
`default_nettype wire

// [verification/tdc_timing_control_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module tdc_timing_control_assertions #(
	parameter int PER_8K = tdc_pkg::PER_8K_CY
)(
	// Clock and reset
	input wire logic              clock,
	input wire logic              nrst,
	// Pins and loop side
	input wire logic              networkReference,
	input wire logic              serialInputFramePulse,
	input wire logic [2:0]        loopMode,
	input wire logic              multiplierUsesInputClock,
	input wire logic              loopReference,
	input wire logic              freqOffsetEnable,
	input wire logic signed [7:0] phaseError,
	input wire logic              inputFrameStart,
	input wire logic              referenceFailFlag
);
	localparam int QUIET = 4 * PER_8K;
	int   quiet;
	int   next_quiet;
	logic lastRef;
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (!nrst);
	always_comb
	begin
		next_quiet = quiet;
		// Silence is judged on the reference the loop uses, locked only
		if (loopReference != lastRef || loopMode != 3'h1)
			next_quiet = 0;
		else if (quiet < QUIET)
			next_quiet = quiet + 1;
	end
	// Cleared in reset so old silence is never blamed
	always_ff @(posedge clock)
	begin
		quiet <= nrst ? next_quiet : 0;
		lastRef <= loopReference;
	end
	a_reset_locked: assert property ($rose(nrst) |->
		loopMode == 3'h1 && !multiplierUsesInputClock)
		else $error("not locked after reset");
	a_mode_onehot: assert property ($onehot(loopMode))
		else $error("mode not one-hot");
	a_input_mux: assert property ($past(nrst) && $stable(loopMode) |->
		multiplierUsesInputClock == (loopMode == 3'h4))
		else $error("multiplier input wrong");
	a_offset_gate: assert property ($past(nrst) && $stable(loopMode) |->
		freqOffsetEnable == (loopMode == 3'h1))
		else $error("offset enable wrong");
	a_phase_idle: assert property ((loopMode != 3'h1) [*3] |->
		phaseError == 8'sh00)
		else $error("phase error outside locked");
	a_ref_gated: assert property ((loopMode != 3'h1) [*8] |->
		!loopReference)
		else $error("reference leaks outside locked");
	a_frame_single: assert property (inputFrameStart |=> !inputFrameStart)
		else $error("frame start too long");
	a_frame_cause: assert property (inputFrameStart |->
		!$past(serialInputFramePulse, 2) || !$past(serialInputFramePulse, 3)
		|| !$past(serialInputFramePulse, 4))
		else $error("frame start without frame pulse");
	a_fail_silent: assert property (quiet >= QUIET |-> referenceFailFlag)
		else $error("silent reference not flagged");
	c_bypass: cover property (loopMode == 3'h4);
	c_fail: cover property ($rose(referenceFailFlag));
	c_frame: cover property (inputFrameStart);
	c_ref_idle: cover property (quiet == QUIET);
	c_net_edge: cover property ($rose(networkReference));
endmodule : tdc_timing_control_assertions
bind tdc_timing_control tdc_timing_control_assertions #(.PER_8K(PER_8K))
	tdc_timing_control_assertions_i (.clock(clock), .nrst(nrst),
	.networkReference(networkReference),
	.serialInputFramePulse(serialInputFramePulse), .loopMode(loopMode),
	.multiplierUsesInputClock(multiplierUsesInputClock),
	.loopReference(loopReference), .freqOffsetEnable(freqOffsetEnable),
	.phaseError(phaseError), .inputFrameStart(inputFrameStart),
	.referenceFailFlag(referenceFailFlag));
`default_nettype wire

// [verification/tdc_ref_source.sv]
`timescale 1ns/1ps
`default_nettype none
module tdc_ref_source #(
	parameter int FRAME_CY = 384
)(
	// Clock
	input  wire logic       clock,
	// Reference shape
	input  wire logic [7:0] hiCy,
	input  wire logic [7:0] loCy,
	input  wire logic       run,
	// Timing outputs
	output var  logic       refOut,
	output var  logic       serialClk,
	output var  logic       framePulse
);
	logic [8:0] refCnt = 9'h000;
	logic [8:0] frameCnt = 9'h000;
	// Stopped reference rests low, as a dead line would
	always @(posedge clock)
	begin
		frameCnt <= (frameCnt == 9'(FRAME_CY - 1)) ? 9'h000 : frameCnt + 9'h001;
		if (refCnt >= {1'b0, hiCy} + {1'b0, loCy} - 9'h001)
			refCnt <= 9'h000;
		else
			refCnt <= refCnt + 9'h001;
		refOut <= run && (refCnt < {1'b0, hiCy});
	end
	// Frame pulse low over one whole input clock period
	assign serialClk = frameCnt[4];
	assign framePulse = (frameCnt >= 9'h020);
endmodule : tdc_ref_source
`default_nettype wire

// [verification/tdm_timing_dpll_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tdm_timing_dpll_control_tb;
	localparam logic [7:0] CTL = tdc_pkg::MAIN_CONTROL_OFS;
	localparam logic [7:0] MOD = tdc_pkg::LOOP_MODE_OFS;
	localparam logic [7:0] HKP = tdc_pkg::HOUSEKEEP_OFS;
	localparam logic [7:0] ADJ = tdc_pkg::OUT_ADJUST_OFS;
	logic		clock = 1'b0, nrst = 1'b0, run = 1'b1;
	logic		awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic		arvalid = 1'b0, rready = 1'b0;
	logic [7:0]	awaddr = 8'h00, araddr = 8'h00, hiCy = 8'h31, loCy = 8'h31;
	logic [31:0]	wdata = 32'h0000_0000, seed = 32'h0000_b02f;
	logic [31:0]	q, d, rdata;
	logic [1:0]	bresp, rresp, resp;
	logic [2:0]	loopMode;
	logic		awready, wready, bvalid, arready, rvalid, useCki, offEn;
	logic		loopRef, frameStart, failFlag, sck, fp, netRef;
	logic signed [7:0]	phaseError;
	logic [7:0]	pe;
	logic [7:0]	mMode[8] = '{8'h04, 8'h04, 8'h02, 8'h00, 8'h10, 8'h04,
		8'h04, 8'h04};
	logic [7:0]	mHi[8] = '{8'h31, 8'h0a, 8'h41, 8'h41, 8'h41, 8'h31,
		8'h31, 8'h35};
	logic [7:0]	mLo[8] = '{8'h31, 8'h58, 8'h41, 8'h41, 8'h41, 8'h31,
		8'h31, 8'h35};
	// Waits of 13000 and 17000 span two full 64-edge windows after a rate change; 9500 spans one
	int		mWait[8] = '{13000, 2000, 17000, 2000, 2000, 2000,
		13000, 9500};
	int		errTotal = 0, compares = 0, cyc = 0, l0, n, nFrames = 0;
	always #2.5 clock = ~clock;
	tdc_timing_control #(.PER_8K(384)) tdc_timing_control_i (
		.clock(clock), .nrst(nrst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .serialInputClock(sck),
		.serialInputFramePulse(fp), .networkReference(netRef),
		.loopMode(loopMode), .multiplierUsesInputClock(useCki),
		.loopReference(loopRef), .freqOffsetEnable(offEn),
		.phaseError(phaseError), .inputFrameStart(frameStart),
		.referenceFailFlag(failFlag));
	tdc_ref_source #(.FRAME_CY(384)) tdc_ref_source_i (.clock(clock),
		.hiCy(hiCy), .loCy(loCy), .run(run), .refOut(netRef),
		.serialClk(sck), .framePulse(fp));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function automatic logic [2:0] expMode(input logic bp, input logic fr);
		return bp ? 3'h4 : (fr ? 3'h2 : 3'h1);
	endfunction : expMode
	task automatic wrapUp();
		$display("compares %0d mismatches %0d", compares, errTotal);
		if (errTotal == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrapUp
	task automatic chk(input string s, input logic [31:0] got,
		input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			errTotal++;
			$display("wrong value %s exp %h got %h", s, exp, got);
		end
	endtask : chk
	// Both channels offered at once, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		output logic [1:0] r);
		// Fresh edge first, so back-to-back calls never drive twice
		@(posedge clock);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] r);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		v = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic lat(output int v);
		time t0;
		@(posedge netRef);
		t0 = $time;
		@(posedge loopRef);
		v = int'(($time - t0) / 5);
	endtask : lat
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (frameStart)
			nFrames <= nFrames + 1;
		if (cyc == 90000)
		begin
			errTotal++;
			wrapUp();
		end
	end
	initial
	begin
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		chk("mode", 32'(loopMode), 32'h0000_0001);
		rd(CTL, q, resp);
		chk("ctrl", q, 32'h0000_0000);
		rd(MOD, q, resp);
		chk("modereg", q, 32'h0000_0000);
		rd(ADJ, q, resp);
		chk("adjust", q, 32'h0000_0000);
		n = nFrames;
		repeat (3840) @(posedge clock);
		chk("frames", 32'(nFrames - n), 32'h0000_000a);
		wr(8'h20, xs(), resp);
		chk("wresp", 32'(resp), 32'h0000_0002);
		rd(8'h20, q, resp);
		chk("rresp", 32'(resp), 32'h0000_0002);
		chk("rdata", q, 32'h0000_0000);
		for (int i = 0; i < 8; i++)
		begin
			d = xs();
			d[0] = i[0];
			if (d[4])
				d[2:1] = 2'b00;
			wr(CTL, {17'h0_0000, i[1], 14'h0000}, resp);
			wr(MOD, d, resp);
			wr(ADJ, d, resp);
			repeat (4) @(posedge clock);
			pe = (i[1:0] == 2'b00) ? {d[6], d[6:0]} : 8'h00;
			chk("mode", 32'(loopMode), 32'(expMode(i[1], i[0])));
			chk("mux", 32'(useCki), 32'(i[1]));
			chk("offset", 32'(offEn), 32'(i[1:0] == 2'b00));
			chk("phase", 32'(phaseError === pe || phaseError === pe + 8'h01),
				32'h0000_0001);
			rd(MOD, q, resp);
			chk("modereg", q & 32'h0000_001f, d & 32'h0000_001f);
			rd(ADJ, q, resp);
			chk("adjust", q & 32'h0000_077f, d & 32'h0000_077f);
		end
		wr(CTL, 32'h0000_0000, resp);
		hiCy <= 8'h1e;
		loCy <= 8'h44;
		for (int k = 0; k < 3; k++)
		begin
			wr(MOD, (k == 2) ? 32'h0000_000c : 32'h0000_0004, resp);
			wr(ADJ, (k == 1) ? 32'h0000_0700 : 32'h0000_0000, resp);
			lat(n);
			lat(n);
			if (k == 0)
				l0 = n;
			chk("delay", 32'(n), 32'(l0 + k * 7 + (k / 2) * 16));
		end
		for (int k = 0; k < 8; k++)
		begin
			hiCy <= mHi[k];
			loCy <= mLo[k];
			run <= (k != 5);
			wr(MOD, 32'(mMode[k]), resp);
			repeat (mWait[k]) @(posedge clock);
			rd(HKP, q, resp);
			chk("failbit", q & 32'h0000_0001, 32'(k[0]));
			chk("failpin", 32'(failFlag), 32'(k[0]));
		end
		run <= 1'b1;
		wr(CTL, 32'h0000_4000, resp);
		nrst <= 1'b0;
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		repeat (2) @(posedge clock);
		chk("mode", 32'(loopMode), 32'h0000_0001);
		rd(CTL, q, resp);
		chk("ctrl", q, 32'h0000_0000);
		wrapUp();
	end
endmodule : tdm_timing_dpll_control_tb
`default_nettype wire
